//--- inc/cpu_arith_pkg.sv
// constants and types shared by the arithmetic/compare decode block
package cpu_arith_pkg;
  // ****************************************************************
  // register map (byte addresses) and field positions
  // ****************************************************************
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_INSN     = 8'h04;
  localparam logic [7:0]  OFF_OPND     = 8'h08;
  localparam logic [7:0]  OFF_FLAGS    = 8'h0C;
  localparam logic [7:0]  OFF_PC       = 8'h10;
  localparam logic [7:0]  OFF_RESULT   = 8'h14;
  localparam logic [7:0]  OFF_STATUS   = 8'h18;
  localparam logic [7:0]  OFF_INTERRUPT_CONTROL_REG   = 8'h1C;
  localparam int          START_BIT    = 0;
  localparam int          FLAGS_LSB    = 2;
  localparam int          IRQ_EN_BIT   = 7;
  // ****************************************************************
  // opcodes
  // ****************************************************************
  localparam logic [7:0]  OP_PREFIX    = 8'h1F;
  localparam logic [3:0]  GRP_ADD      = 4'h0;
  localparam logic [3:0]  GRP_ADC      = 4'h1;
  localparam logic [3:0]  GRP_CP       = 4'hA;
  localparam logic [3:0]  LO_FIRST     = 4'h2;
  localparam logic [3:0]  LO_WIDE      = 4'h4;
  localparam logic [3:0]  LO_EXT       = 4'h8;
  localparam logic [3:0]  LO_LAST      = 4'h9;
  localparam logic [3:0]  LO_LOOP      = 4'hA;
  localparam logic [7:0]  OP_CP_FIRST  = 8'hA2;
  localparam logic [7:0]  OP_CP_EXT    = 8'hA8;
  localparam logic [7:0]  OP_INVERT    = 8'h60;
  localparam logic [7:0]  OP_DECADJ    = 8'h40;
  localparam logic [7:0]  OP_DEC       = 8'h30;
  localparam logic [7:0]  OP_WORD_MINUS_ONE      = 8'h80;
  localparam logic [7:0]  OP_IRQ_OFF   = 8'h8F;
  localparam logic [7:0]  OP_IRQ_ON    = 8'h9F;
  // ****************************************************************
  // fetch and execute cycle counts
  // ****************************************************************
  localparam logic [3:0]  CYC_ONE      = 4'h1;
  localparam logic [3:0]  CYC_TWO      = 4'h2;
  localparam logic [3:0]  CYC_THREE    = 4'h3;
  localparam logic [3:0]  CYC_FOUR     = 4'h4;
  localparam logic [3:0]  CYC_FIVE     = 4'h5;
  localparam logic [3:0]  CYC_SIX      = 4'h6;
  // ****************************************************************
  // arithmetic constants
  // ****************************************************************
  localparam logic [3:0]  DA_LO_LIMIT  = 4'h9;
  localparam logic [7:0]  DA_HI_LIMIT  = 8'h99;
  localparam logic [7:0]  DA_LO_FIX    = 8'h06;
  localparam logic [7:0]  DA_HI_FIX    = 8'h60;
  localparam logic [7:0]  BYTE_ONE     = 8'h01;
  localparam logic [15:0] WORD_ONE     = 16'h0001;
  localparam logic [7:0]  BYTE_MIN_NEG = 8'h80;
  localparam logic [15:0] WORD_MIN_NEG = 16'h8000;
  localparam logic [15:0] PC_STEP      = 16'h0002;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {logic c; logic z; logic s; logic v; logic d; logic h;} flags_t;
  typedef struct packed {
    logic [7:0]  disp;
    logic [14:0] rsvd;
    logic        prefix;
    logic [7:0]  opcode;
  } insn_t;
  typedef struct packed {logic [7:0] rsvd; logic [7:0] src; logic [15:0] dst;} opnd_t;
  typedef struct packed {
    logic [7:0]  rsvd;
    logic [3:0]  wreg;
    logic [2:0]  rsvd2;
    logic        store;
    logic [15:0] data;
  } result_t;
  typedef struct packed {
    logic [15:0] rsvd;
    logic [3:0]  exec;
    logic [3:0]  fetch;
    logic [5:0]  rsvd2;
    logic        illegal;
    logic        busy;
  } status_t;
  typedef enum logic {ST_IDLE, ST_EXEC} state_t;
  typedef enum logic [3:0] {
    OPK_ADD, OPK_ADC, OPK_CP, OPK_CPC, OPK_INV, OPK_DA, OPK_DEC, OPK_WORD_MINUS_ONE,
    OPK_IRQ_OFF, OPK_IRQ_ON, OPK_LOOP, OPK_BAD
  } kind_t;
endpackage : cpu_arith_pkg

//--- hdl/cpu_arith_compare_decode.sv
// decode and execute of add, compare, adjust, decrement and irq-gate instructions
//
// Behaviour
// RULE1: add_with_carry uses opcodes 14 to 17 (register and literal forms), fetch 3, execute 3 or 4.
// RULE2: add_with_carry_extended stores dst+src+carry, opcodes 18 and 19, fetch 4, execute 3.
// RULE3: plain add stores dst+src over opcodes 02 to 07, sets C Z S V H from it and clears D.
// RULE4: add_extended uses opcodes 08 and 09, fetch 4, execute 3, flags as plain add.
// RULE5: bitwise_invert (60, 61) stores the ones' complement, Z S follow, V clears, rest kept.
// RULE6: compare_op (A2 to A7) subtracts without storing, C Z S V follow, D and H kept.
// RULE7: compare_with_carry is prefix 1F plus A2 to A7, also subtracts carry, one more fetch.
// RULE8: compare_with_carry_extended is 1F plus A8 or A9, fetch 5, execute 3.
// RULE9: compare_extended is A8 or A9, fetch 4, execute 3, C Z S V follow, D and H kept.
// RULE10: decimal_adjust (40, 41) corrects to packed decimal, C Z S follow, D and H kept.
// RULE11: minus_one_op (30, 31) subtracts one from a byte, Z S V follow, carry kept.
// RULE12: word_minus_one (80, 81) decrements a 16-bit pair, execute 5 or 6, carry kept.
// RULE13: global_irq_off (8F) clears interrupt_control_reg bit 7, fetch 1, execute 2, no flags.
// RULE14: global_irq_on (9F) sets interrupt_control_reg bit 7, fetch 1, execute 2, no flags.
// RULE15: loop_count_branch (x A) decrements a register and branches when nonzero, no flags.
// RULE16: its register number is the opcode upper nibble, displacement signed from next address.
// RULE17: add_with_carry opcodes 12 and 13 take fetch 2 and set flags like add, D cleared.
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module cpu_arith_compare_decode
  import cpu_arith_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             irq_enable
);
  state_t      state,     next_state;
  logic [3:0]  cnt,       next_cnt;
  insn_t       insn,      next_insn;
  opnd_t       opnd,      next_opnd;
  flags_t      flags,     next_flags;
  logic [15:0] pc,        next_pc;
  logic [7:0]  interrupt_control_reg,    next_interrupt_control_reg;
  result_t     result,    next_result;
  logic        illegal,   next_illegal;
  logic [3:0]  fetch_cyc, next_fetch_cyc;
  logic [3:0]  exec_cyc,  next_exec_cyc;
  logic        next_pready;
  logic [31:0] next_prdata;
  logic        next_pslverr;

  kind_t       kind;
  logic [3:0]  dfetch;
  logic [3:0]  dexec;
  logic [3:0]  lo;
  logic [3:0]  hi;
  logic [7:0]  d;
  logic [7:0]  s;
  logic        cin;
  logic        sub;
  logic [8:0]  sum;
  logic [4:0]  half;
  logic        ovf;
  logic        da_lo;
  logic        da_hi;
  logic [7:0]  da_fix;
  flags_t      nf;
  logic [15:0] r;
  logic        store;
  logic [15:0] npc;
  logic [7:0]  nirq;
  logic        wr;
  logic        start;
  logic        commit;
  status_t     st;

  assign irq_enable = interrupt_control_reg[IRQ_EN_BIT];

  // ****************************************************************
  // opcode decode
  // ****************************************************************
  always_comb begin
    lo     = insn.opcode[3:0];
    hi     = insn.opcode[7:4];
    kind   = OPK_BAD;
    dfetch = CYC_TWO;
    dexec  = CYC_TWO;
    if (lo == LO_LOOP) begin
      kind  = OPK_LOOP;                                        // see RULE15
      dexec = CYC_THREE;
    end else if (lo >= LO_FIRST && lo <= LO_LAST &&
                 (hi == GRP_ADD || hi == GRP_ADC || hi == GRP_CP)) begin
      kind   = (hi == GRP_ADD) ? OPK_ADD : (hi == GRP_ADC) ? OPK_ADC : OPK_CP;
      // register pairs fetch 2, full addresses 3, twelve-bit locations 4
      dfetch = (lo >= LO_EXT) ? CYC_FOUR : (lo >= LO_WIDE) ? CYC_THREE : CYC_TWO; // see RULE1
      dexec  = (lo < LO_EXT && lo[0]) ? CYC_FOUR : CYC_THREE;  // see RULE4
    end else if (insn.opcode[7:1] == OP_INVERT[7:1]) begin
      kind  = OPK_INV;                                         // see RULE5
      dexec = insn.opcode[0] ? CYC_THREE : CYC_TWO;
    end else if (insn.opcode[7:1] == OP_DECADJ[7:1]) begin
      kind  = OPK_DA;
      dexec = insn.opcode[0] ? CYC_THREE : CYC_TWO;
    end else if (insn.opcode[7:1] == OP_DEC[7:1]) begin
      kind  = OPK_DEC;                                         // see RULE11
      dexec = insn.opcode[0] ? CYC_THREE : CYC_TWO;
    end else if (insn.opcode[7:1] == OP_WORD_MINUS_ONE[7:1]) begin
      kind  = OPK_WORD_MINUS_ONE;                                        // see RULE12
      dexec = insn.opcode[0] ? CYC_SIX : CYC_FIVE;
    end else if (insn.opcode == OP_IRQ_OFF || insn.opcode == OP_IRQ_ON) begin
      kind   = (insn.opcode == OP_IRQ_OFF) ? OPK_IRQ_OFF : OPK_IRQ_ON; // see RULE13
      dfetch = CYC_ONE;                                        // see RULE14
    end
    // the prefix is only legal in front of a compare
    if (insn.prefix) begin
      if (kind == OPK_CP) begin
        kind   = OPK_CPC;                                      // see RULE7
        dfetch = dfetch + CYC_ONE;                             // see RULE8
      end else begin
        kind = OPK_BAD;
      end
    end
  end

  // ****************************************************************
  // execute datapath
  // ****************************************************************
  always_comb begin
    d      = opnd.dst[7:0];
    s      = opnd.src;
    cin    = (kind == OPK_ADC || kind == OPK_CPC) ? flags.c : 1'b0; // see RULE2
    sub    = (kind == OPK_CP || kind == OPK_CPC);
    sum    = sub ? ({1'b0, d} - {1'b0, s} - {8'h00, cin})       // see RULE6
                 : ({1'b0, d} + {1'b0, s} + {8'h00, cin});
    half   = {1'b0, d[3:0]} + {1'b0, s[3:0]} + {4'h0, cin};
    ovf    = sub ? (d[7] != s[7]) && (sum[7] != d[7]) : (d[7] == s[7]) && (sum[7] != d[7]);
    da_lo  = flags.h || (d[3:0] > DA_LO_LIMIT);
    da_hi  = flags.c || (d > DA_HI_LIMIT);
    da_fix = (da_hi ? DA_HI_FIX : 8'h00) | (da_lo ? DA_LO_FIX : 8'h00);
    nf     = flags;
    r      = 16'h0000;
    store  = 1'b0;
    npc    = pc;
    nirq   = interrupt_control_reg;
    case (kind)
      OPK_ADD, OPK_ADC: begin
        r[7:0] = sum[7:0];                                     // see RULE3
        nf.c   = sum[8];
        nf.v   = ovf;
        nf.d   = 1'b0;                                         // see RULE17
        nf.h   = half[4];
        store  = 1'b1;
      end
      OPK_CP, OPK_CPC: begin
        r[7:0] = sum[7:0];                                     // see RULE9
        nf.c   = sum[8];
        nf.v   = ovf;
      end
      OPK_INV: begin
        r[7:0] = ~d;
        nf.v   = 1'b0;
        store  = 1'b1;
      end
      OPK_DA: begin
        // after a subtract the correction is taken away instead
        r[7:0] = flags.d ? d - da_fix : d + da_fix;            // see RULE10
        nf.c   = da_hi;
        nf.v   = 1'b0;
        store  = 1'b1;
      end
      OPK_DEC: begin
        r[7:0] = d - BYTE_ONE;
        nf.v   = (d == BYTE_MIN_NEG);
        store  = 1'b1;
      end
      OPK_WORD_MINUS_ONE: begin
        r     = opnd.dst - WORD_ONE;
        nf.v  = (opnd.dst == WORD_MIN_NEG);
        store = 1'b1;
      end
      OPK_IRQ_OFF: nirq[IRQ_EN_BIT] = 1'b0;                    // see RULE13
      OPK_IRQ_ON:  nirq[IRQ_EN_BIT] = 1'b1;                    // see RULE14
      OPK_LOOP: begin
        r[7:0] = d - BYTE_ONE;
        store  = 1'b1;
        npc    = pc + PC_STEP;                                 // see RULE16
        if (r[7:0] != 8'h00) begin
          npc = pc + PC_STEP + {{8{insn.disp[7]}}, insn.disp};  // see RULE15
        end
      end
      default: r = 16'h0000;
    endcase
    if (kind != OPK_IRQ_OFF && kind != OPK_IRQ_ON && kind != OPK_LOOP) begin
      nf.z = (kind == OPK_WORD_MINUS_ONE) ? (r == 16'h0000) : (r[7:0] == 8'h00);
      nf.s = (kind == OPK_WORD_MINUS_ONE) ? r[15] : r[7];
    end
  end

  // ****************************************************************
  // sequencer and software-visible state
  // ****************************************************************
  always_comb begin
    wr             = psel && penable && pready && pwrite;
    start          = wr && paddr == OFF_CTRL && pwdata[START_BIT] && state == ST_IDLE;
    commit         = state == ST_EXEC && cnt == CYC_ONE;
    next_state     = state;
    next_cnt       = cnt;
    next_insn      = insn;
    next_opnd      = opnd;
    next_flags     = flags;
    next_pc        = pc;
    next_interrupt_control_reg    = interrupt_control_reg;
    next_result    = result;
    next_illegal   = illegal;
    next_fetch_cyc = fetch_cyc;
    next_exec_cyc  = exec_cyc;
    // operands stay frozen while an instruction runs
    if (wr && state == ST_IDLE) begin
      case (paddr)
        OFF_INSN:   next_insn   = insn_t'(pwdata);
        OFF_OPND:   next_opnd   = opnd_t'(pwdata);
        OFF_FLAGS:  next_flags  = flags_t'(pwdata[FLAGS_LSB +: $bits(flags_t)]);
        OFF_PC:     next_pc     = pwdata[15:0];
        OFF_INTERRUPT_CONTROL_REG: next_interrupt_control_reg = pwdata[7:0];
        default:    next_pc     = pc;
      endcase
    end
    if (start) begin
      next_fetch_cyc = dfetch;
      next_exec_cyc  = dexec;
      next_illegal   = (kind == OPK_BAD);
      if (kind != OPK_BAD) begin
        next_state = ST_EXEC;
        next_cnt   = dexec;
      end
    end
    if (state == ST_EXEC) begin
      next_cnt = cnt - CYC_ONE;
      if (commit) begin
        next_state        = ST_IDLE;
        next_flags        = nf;
        next_pc           = npc;
        next_interrupt_control_reg       = nirq;
        next_result       = '0;
        next_result.data  = r;
        next_result.store = store;
        next_result.wreg  = insn.opcode[7:4];                  // see RULE16
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= ST_IDLE;
      cnt       <= '0;
      insn      <= '0;
      opnd      <= '0;
      flags     <= '0;
      pc        <= '0;
      interrupt_control_reg    <= '0;
      result    <= '0;
      illegal   <= 1'b0;
      fetch_cyc <= '0;
      exec_cyc  <= '0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      insn      <= next_insn;
      opnd      <= next_opnd;
      flags     <= next_flags;
      pc        <= next_pc;
      interrupt_control_reg    <= next_interrupt_control_reg;
      result    <= next_result;
      illegal   <= next_illegal;
      fetch_cyc <= next_fetch_cyc;
      exec_cyc  <= next_exec_cyc;
    end
  end

  // ****************************************************************
  // apb slave: one wait state, error on unmapped addresses
  // ****************************************************************
  always_comb begin
    st           = '0;
    st.busy      = (state == ST_EXEC);
    st.illegal   = illegal;
    st.fetch     = fetch_cyc;
    st.exec      = exec_cyc;
    next_pready  = psel && penable && !pready;
    next_prdata  = '0;
    next_pslverr = 1'b0;
    if (next_pready) begin
      case (paddr)
        OFF_CTRL:   next_prdata = {31'h0, st.busy};
        OFF_INSN:   next_prdata = insn;
        OFF_OPND:   next_prdata = opnd;
        OFF_FLAGS:  next_prdata = 32'(flags) << FLAGS_LSB;
        OFF_PC:     next_prdata = {16'h0000, pc};
        OFF_RESULT: next_prdata = result;
        OFF_STATUS: next_prdata = st;
        OFF_INTERRUPT_CONTROL_REG: next_prdata = {24'h000000, interrupt_control_reg};
        default:    next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= next_pready;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_carry_sum: assert property (commit && kind == OPK_ADC |=> // see RULE1 RULE2 RULE17
    result.data[7:0] == $past(opnd.dst[7:0] + opnd.src + {7'h00, flags.c}) && !flags.d)
    else $error("add with carry result or flags wrong");
  chk_add_flags: assert property (commit && kind == OPK_ADD |=> // see RULE3
    !flags.d && result.store && flags.z == (result.data[7:0] == 8'h00))
    else $error("add flags wrong");
  chk_ext_timing: assert property (start && !insn.prefix && kind != OPK_LOOP && // see RULE4 RULE9
    insn.opcode[3:0] >= LO_EXT && insn.opcode[3:0] <= LO_LAST && kind != OPK_BAD
    |=> fetch_cyc == CYC_FOUR && exec_cyc == CYC_THREE ##1 state == ST_EXEC [*2])
    else $error("extended form timing wrong");
  chk_invert_val: assert property (commit && kind == OPK_INV |=> // see RULE5
    result.data[7:0] == ~$past(opnd.dst[7:0]) && !flags.v && flags.c == $past(flags.c))
    else $error("invert wrong");
  chk_cmp_keeps: assert property (commit && (kind == OPK_CP || kind == OPK_CPC) |=> // see RULE6
    !result.store && flags.d == $past(flags.d) && flags.h == $past(flags.h))
    else $error("compare stored or changed d or h");
  chk_prefix_fetch: assert property (start && insn.prefix && insn.opcode == OP_CP_FIRST // see RULE7
    |=> fetch_cyc == CYC_THREE && !illegal)
    else $error("prefixed compare fetch count wrong");
  chk_prefix_ext: assert property (start && insn.prefix && insn.opcode == OP_CP_EXT // see RULE8
    |=> fetch_cyc == CYC_FIVE && exec_cyc == CYC_THREE)
    else $error("prefixed extended compare timing wrong");
  chk_adjust_keep: assert property (commit && kind == OPK_DA |=> // see RULE10
    flags.d == $past(flags.d) && flags.h == $past(flags.h))
    else $error("decimal adjust changed d or h");
  chk_dec_carry: assert property (commit && kind == OPK_DEC |=> // see RULE11
    flags.c == $past(flags.c) && result.data[7:0] == $past(opnd.dst[7:0]) - BYTE_ONE)
    else $error("byte decrement wrong");
  chk_word_len: assert property (start && kind == OPK_WORD_MINUS_ONE && !insn.opcode[0] |=> // see RULE12
    state == ST_EXEC [*5] ##1 state == ST_IDLE && flags.c == $past(flags.c, 6))
    else $error("word decrement timing wrong");
  // commit falls on the second busy edge, so the gate is seen one edge later
  chk_irq_off: assert property (start && kind == OPK_IRQ_OFF |=> // see RULE13
    ##2 !irq_enable && flags == $past(flags) && state == ST_IDLE)
    else $error("irq off wrong");
  chk_irq_on: assert property (start && kind == OPK_IRQ_ON |=> // see RULE14
    fetch_cyc == CYC_ONE ##2 irq_enable && flags == $past(flags) && state == ST_IDLE)
    else $error("irq on wrong");
  chk_loop_exit: assert property (commit && kind == OPK_LOOP && // see RULE15 RULE16
    opnd.dst[7:0] == BYTE_ONE |=> pc == $past(pc) + PC_STEP && flags == $past(flags)
    && result.wreg == $past(insn.opcode[7:4]))
    else $error("loop count fall-through wrong");

  cov_loop_taken: cover property (commit && kind == OPK_LOOP && opnd.dst[7:0] != BYTE_ONE);
  cov_cmp_carry:  cover property (commit && kind == OPK_CPC);
  cov_word_dec:   cover property (commit && kind == OPK_WORD_MINUS_ONE);
  cov_bad_opcode: cover property (start && kind == OPK_BAD);
endmodule : cpu_arith_compare_decode

//--- tb/test_cpu_arith_compare_decode.sv
// self-checking bench: instructions run through the register interface
`timescale 1ns/1ps
module test_cpu_arith_compare_decode;
  import cpu_arith_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        irq_enable;
  logic [7:0]  disp;
  logic [31:0] q;
  logic        err;
  int          n_mismatch;
  int          num_checks;

  cpu_arith_compare_decode uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .irq_enable(irq_enable));

  // ****************************************************************
  // reporting
  // ****************************************************************
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // ****************************************************************
  // apb master: entered just after a rising edge, leaves one idle cycle
  // ****************************************************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_mismatch++;
      stop_test();
    end
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rq;
    logic        re;
    apb(1'b1, a, d, rq, re);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] rq);
    logic re;
    apb(1'b0, a, 32'h0000_0000, rq, re);
  endtask : rd

  // run one instruction; flags are {c,z,s,v,d,h}, result is {store,data}
  task automatic op(input logic [8:0] code, input logic [15:0] dst, input logic [7:0] src,
                    input logic [5:0] fin, input logic [5:0] efl, input logic [3:0] ef,
                    input logic [3:0] ee, input logic [16:0] eres, input logic cr);
    logic [31:0] rq;
    int          n;
    wr(OFF_FLAGS, {24'h00_0000, fin, 2'b00});
    wr(OFF_OPND, {8'h00, src, dst});
    wr(OFF_INSN, {disp, 15'h0000, code});
    wr(OFF_CTRL, 32'h0000_0001);
    n = 0;
    rq = 32'h0000_0001;
    while (rq[0] !== 1'b0 && n < 20) begin
      rd(OFF_STATUS, rq);
      n++;
    end
    if (rq[0] !== 1'b0) begin
      n_mismatch++;
      stop_test();
    end
    chk({16'h0000, rq[15:8]}, {16'h0000, ee, ef}, "cycle counts");
    rd(OFF_FLAGS, rq);
    chk({26'h0, rq[7:2]}, {26'h0, efl}, "flags");
    if (cr) begin
      rd(OFF_RESULT, rq);
      chk({15'h0, rq[16:0]}, {15'h0, eres}, "result");
    end
  endtask : op

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [16:0] fres [4];
    logic [5:0]  fflg [4];
    logic [3:0]  ef;
    n_mismatch = 0;
    num_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    disp = 8'h00;
    fres = '{17'h10051, 17'h10052, 17'h0001F, 17'h0001E};
    fflg = '{6'h01, 6'h01, 6'h02, 6'h02};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_INTERRUPT_CONTROL_REG, q);
    chk(q, 32'h0000_0000, "irq control after reset");
    // unmapped word answers with an error
    apb(1'b0, 8'h20, 32'h0000_0000, q, err);
    chk({31'h0, err}, 32'h0000_0001, "unmapped error");
    // add, add with carry, compare, compare with carry over all forms
    for (int g = 0; g < 4; g++) begin
      for (int lo = 2; lo < 10; lo++) begin
        ef = (lo > 7) ? 4'h4 : (lo > 3) ? 4'h3 : 4'h2;
        op({g == 3, (g < 2) ? GRP_ADD + 4'(g) : GRP_CP, 4'(lo)}, 16'h0038, 8'h19, 6'h22,
           fflg[g], ef + 4'(g == 3), (lo > 7) ? 4'h3 : lo[0] ? 4'h4 : 4'h3, fres[g],
           1'b1);
      end
    end
    op(9'h002, 16'h007F, 8'h01, 6'h02, 6'h0D, 4'h2, 4'h3, 17'h10080, 1'b1);
    op(9'h007, 16'h00FF, 8'h01, 6'h00, 6'h31, 4'h3, 4'h4, 17'h10000, 1'b1);
    op(9'h0A2, 16'h0010, 8'h20, 6'h01, 6'h29, 4'h2, 4'h3, 17'h00000, 1'b0);
    op(9'h060, 16'h005A, 8'h00, 6'h35, 6'h29, 4'h2, 4'h2, 17'h100A5, 1'b1);
    op(9'h061, 16'h005A, 8'h00, 6'h35, 6'h29, 4'h2, 4'h3, 17'h100A5, 1'b1);
    op(9'h040, 16'h003C, 8'h00, 6'h04, 6'h00, 4'h2, 4'h2, 17'h10042, 1'b1);
    op(9'h041, 16'h00A0, 8'h00, 6'h00, 6'h30, 4'h2, 4'h3, 17'h10000, 1'b1);
    op(9'h030, 16'h0080, 8'h00, 6'h23, 6'h27, 4'h2, 4'h2, 17'h1007F, 1'b1);
    op(9'h031, 16'h0001, 8'h00, 6'h20, 6'h30, 4'h2, 4'h3, 17'h10000, 1'b1);
    op(9'h080, 16'h8000, 8'h00, 6'h00, 6'h04, 4'h2, 4'h5, 17'h17FFF, 1'b1);
    op(9'h081, 16'h0100, 8'h00, 6'h20, 6'h20, 4'h2, 4'h6, 17'h100FF, 1'b1);
    // global interrupt gate touches bit 7 only
    wr(OFF_INTERRUPT_CONTROL_REG, 32'h0000_0005);
    op(9'h09F, 16'h0000, 8'h00, 6'h2A, 6'h2A, 4'h1, 4'h2, 17'h00000, 1'b0);
    rd(OFF_INTERRUPT_CONTROL_REG, q);
    chk(q, 32'h0000_0085, "irq control set");
    chk({31'h0, irq_enable}, 32'h0000_0001, "irq enable pin");
    op(9'h08F, 16'h0000, 8'h00, 6'h15, 6'h15, 4'h1, 4'h2, 17'h00000, 1'b0);
    rd(OFF_INTERRUPT_CONTROL_REG, q);
    chk(q, 32'h0000_0005, "irq control cleared");
    chk({31'h0, irq_enable}, 32'h0000_0000, "irq enable pin");
    // loop branch: taken backwards, then falls through at zero
    wr(OFF_PC, 32'h0000_0100);
    disp = 8'hFE;
    op(9'h03A, 16'h0005, 8'h00, 6'h3F, 6'h3F, 4'h2, 4'h3, 17'h10004, 1'b1);
    rd(OFF_PC, q);
    chk({16'h0, q[15:0]}, 32'h0000_0100, "branch taken");
    rd(OFF_RESULT, q);
    chk({28'h0, q[23:20]}, 32'h0000_0003, "working register");
    op(9'h0FA, 16'h0001, 8'h00, 6'h00, 6'h00, 4'h2, 4'h3, 17'h10000, 1'b1);
    rd(OFF_PC, q);
    chk({16'h0, q[15:0]}, 32'h0000_0102, "branch not taken");
    // prefix ahead of a non-compare opcode is refused
    wr(OFF_INSN, 32'h0000_0160);
    wr(OFF_CTRL, 32'h0000_0001);
    rd(OFF_STATUS, q);
    chk({30'h0, q[1:0]}, 32'h0000_0002, "illegal prefix");
    stop_test();
  end
endmodule : test_cpu_arith_compare_decode
